// >>> rtl/slm_status_mon.sv
// status pin routing, lock monitor, interface select and axi4-lite registers
//
// Contract
// - control 3 bits 12:7 route vitals to pins
// - selected reference vital, bits 3.12/3.9
// - reference loss vital, bits 3.11/3.8
// - secondary disabled forces reference loss high
// - unlock vital, bits 3.10/3.7, status 21.2
// - pin lock term inverse of 21.2
// - several enables OR onto a pin
// - pin zero uses bits 12, 11, 10
// - digital detector catches a lone slip; of back-to-back slips only every other one
// - count slips, flag unlock, reset counter
// - sustained large error keeps unlock
// - mid error toggles lock indication
// - tiny error drops lock about 1000 cycles
// - stalled references hold status pin high
// - select input chooses spi, i2c, pin mode
// - pin mode takes presets from five pins
// - writes to read-only bits are ignored
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module slm_status_mon #(
    parameter int HOLD_CYCLES = slm_pkg::LD_HOLD_CYCLES,
    parameter int SLIP_THRESHOLD = slm_pkg::LD_SLIP_THRESHOLD
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // axi4-lite write address and data
    input wire logic [slm_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [slm_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // clock path observation
    input wire logic phase_detector_update_i,
    input wire logic feedback_update_i,
    input wire logic secondary_clock_input_sel_i,
    input wire logic reference_present_i,
    // interface select and presets
    input wire logic [1:0] interface_select_i,
    input wire logic [slm_pkg::PRESET_W-1:0] preset_select_pins_i,
    output slm_pkg::slm_if_t interface_mode_o,
    output logic [slm_pkg::PRESET_W-1:0] preset_config_o,
    output logic preset_valid_o,
    // status pins
    output logic monitor_out_zero_o,
    output logic monitor_out_one_o
);
    import slm_pkg::*;

    logic [REG_W-1:0] ctrl3_reg;
    logic [REG_W-1:0] ctrl4_reg;
    slm_vitals_t vitals;
    slm_pin_en_t en0;
    slm_pin_en_t en1;
    logic unlock;
    logic reference_loss_flag;
    logic pin0_next;
    logic pin1_next;
    logic [REG_W-1:0] stat21;

    // ---------------- vitals ----------------
    slm_lock_det #(
        .HOLD_CYCLES(HOLD_CYCLES),
        .SLIP_THRESHOLD(SLIP_THRESHOLD)
    ) u_lock_det (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .upd_i(phase_detector_update_i),
        .fb_i(feedback_update_i),
        .unlock_o(unlock),
        .slip_o()
    );

    // loss detection needs the secondary path; without it the flag is stuck high.
    // when both references stall the presence input drops, so the flag holds high
    assign reference_loss_flag = ctrl4_reg[SEC_EN_BIT] ? !reference_present_i : 1'b1;

    always_comb begin
        vitals.sel_ref = secondary_clock_input_sel_i;
        vitals.ref_loss = reference_loss_flag;
        vitals.unlock = unlock;
    end

    always_comb begin
        en0.sel = ctrl3_reg[EN0_SEL_BIT];
        en0.los = ctrl3_reg[EN0_LOS_BIT];
        en0.lck = ctrl3_reg[EN0_LCK_BIT];
        en1.sel = ctrl3_reg[EN1_SEL_BIT];
        en1.los = ctrl3_reg[EN1_LOS_BIT];
        en1.lck = ctrl3_reg[EN1_LCK_BIT];
    end

    // pins carry lock, the inverse of the unlock status bit; several enables OR together
    assign pin0_next = (en0.sel & vitals.sel_ref) | (en0.los & vitals.ref_loss)
        | (en0.lck & !vitals.unlock);
    assign pin1_next = (en1.sel & vitals.sel_ref) | (en1.los & vitals.ref_loss)
        | (en1.lck & !vitals.unlock);

    // registered on update edges so combining never glitches the pins
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            monitor_out_zero_o <= 1'b0;
            monitor_out_one_o <= 1'b0;
        end else if (phase_detector_update_i) begin
            monitor_out_zero_o <= pin0_next;
            monitor_out_one_o <= pin1_next;
        end
    end

    always_comb begin
        stat21 = '0;
        stat21[ST_SEL_BIT] = vitals.sel_ref;
        stat21[ST_LOS_BIT] = vitals.ref_loss;
        stat21[ST_UNLOCK_BIT] = vitals.unlock;
    end

    // ---------------- interface select ----------------
    // the unused code 11 falls back to serial spi
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            interface_mode_o <= SLM_IF_SPI;
        end else begin
            case (interface_select_i)
                SI_SPI: interface_mode_o <= SLM_IF_SPI;
                SI_I2C: interface_mode_o <= SLM_IF_I2C;
                SI_PIN: interface_mode_o <= SLM_IF_PIN;
                default: interface_mode_o <= SLM_IF_SPI;
            endcase
        end
    end

    // presets follow the pins only in pin mode; a serial host keeps the last capture
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            preset_config_o <= '0;
            preset_valid_o <= 1'b0;
        end else if (interface_select_i == SI_PIN) begin
            preset_config_o <= preset_select_pins_i;
            preset_valid_o <= 1'b1;
        end else begin
            preset_valid_o <= 1'b0;
        end
    end

    // ---------------- axi4-lite write ----------------
    slm_wr_state_t wr_state_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_commit;

    function automatic logic [REG_W-1:0] slm_merge(
        input logic [REG_W-1:0] old_val,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [REG_W-1:0] wmask
    );
        logic [REG_W-1:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        slm_merge = (old_val & ~lanes) | (data[REG_W-1:0] & lanes);
    endfunction : slm_merge

    assign s_axi_awready_o = !aw_held_reg && wr_state_reg == SLM_WR_IDLE;
    assign s_axi_wready_o = !w_held_reg && wr_state_reg == SLM_WR_IDLE;
    assign s_axi_bvalid_o = wr_state_reg == SLM_WR_RESP;
    assign wr_commit = wr_state_reg == SLM_WR_IDLE && aw_held_reg && w_held_reg;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr_i;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_i;
            wstrb_reg <= s_axi_wstrb_i;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_state_reg <= SLM_WR_IDLE;
            s_axi_bresp_o <= RESP_OKAY;
        end else begin
            case (wr_state_reg)
                SLM_WR_IDLE: begin
                    if (wr_commit) begin
                        wr_state_reg <= SLM_WR_RESP;
                        if (awaddr_reg == ADDR_CTRL3 || awaddr_reg == ADDR_CTRL4
                            || awaddr_reg == ADDR_STAT21) begin
                            s_axi_bresp_o <= RESP_OKAY;
                        end else begin
                            s_axi_bresp_o <= RESP_SLVERR;
                        end
                    end
                end
                SLM_WR_RESP: begin
                    if (s_axi_bready_i) begin
                        wr_state_reg <= SLM_WR_IDLE;
                    end
                end
                default: wr_state_reg <= SLM_WR_IDLE;
            endcase
        end
    end

    // only mask bits take data; status 21 has no storage so writes there vanish
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctrl3_reg <= CTRL3_RST;
        end else if (wr_commit && awaddr_reg == ADDR_CTRL3) begin
            ctrl3_reg <= slm_merge(ctrl3_reg, wdata_reg, wstrb_reg, CTRL3_WMASK);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctrl4_reg <= CTRL4_RST;
        end else if (wr_commit && awaddr_reg == ADDR_CTRL4) begin
            ctrl4_reg <= slm_merge(ctrl4_reg, wdata_reg, wstrb_reg, CTRL4_WMASK);
        end
    end

    // ---------------- axi4-lite read ----------------
    assign s_axi_arready_o = !s_axi_rvalid_o;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= RESP_OKAY;
            case (s_axi_araddr_i)
                ADDR_CTRL3: s_axi_rdata_o <= {16'h0000, ctrl3_reg};
                ADDR_CTRL4: s_axi_rdata_o <= {16'h0000, ctrl4_reg};
                ADDR_STAT21: s_axi_rdata_o <= {16'h0000, stat21};
                default: begin
                    s_axi_rdata_o <= '0;
                    s_axi_rresp_o <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ---------------- checks ----------------
    sequence seq_write_both_held;
        wr_commit;
    endsequence

    sequence seq_write_answered;
        s_axi_bvalid_o ##0 !s_axi_awready_o && !s_axi_wready_o;
    endsequence

    AST_PIN_UPDATE_ONLY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !phase_detector_update_i |=> $stable(monitor_out_zero_o) && $stable(monitor_out_one_o))
        else $error("status pin moved between update edges");
    AST_PIN0_OR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_detector_update_i |=> monitor_out_zero_o ==
        $past((en0.sel & vitals.sel_ref) | (en0.los & vitals.ref_loss) | (en0.lck & !unlock)))
        else $error("pin zero is not the OR of its enabled vitals");
    AST_PIN1_OR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_detector_update_i |=> monitor_out_one_o ==
        $past((en1.sel & vitals.sel_ref) | (en1.los & vitals.ref_loss) | (en1.lck & !unlock)))
        else $error("pin one is not the OR of its enabled vitals");
    AST_LOCK_POLARITY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_detector_update_i && ctrl3_reg[EN0_LCK_BIT] && !ctrl3_reg[EN0_SEL_BIT]
        && !ctrl3_reg[EN0_LOS_BIT] |=> monitor_out_zero_o != $past(stat21[ST_UNLOCK_BIT]))
        else $error("lock pin not inverse of unlock status bit");
    AST_LOSS_FORCED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !ctrl4_reg[SEC_EN_BIT] |-> stat21[ST_LOS_BIT])
        else $error("reference loss not forced high");
    AST_LOSS_TRACKS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ctrl4_reg[SEC_EN_BIT] |-> stat21[ST_LOS_BIT] == !reference_present_i)
        else $error("reference loss does not follow presence");
    AST_SEL_REF: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        stat21[ST_SEL_BIT] == secondary_clock_input_sel_i)
        else $error("selected reference status wrong");
    AST_RO_BITS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (ctrl3_reg & ~CTRL3_WMASK) == '0 && (ctrl4_reg & ~CTRL4_WMASK) == '0)
        else $error("read-only bit took a write");
    AST_WRITE_TAKES: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_commit && awaddr_reg == ADDR_CTRL3 && wstrb_reg == 4'hF
        |=> ctrl3_reg == ($past(wdata_reg[REG_W-1:0]) & CTRL3_WMASK))
        else $error("enable write not stored");
    AST_WRITE_RESP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        seq_write_both_held |=> seq_write_answered)
        else $error("write response missing");
    AST_IF_PIN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        interface_select_i == SI_PIN |=> interface_mode_o == SLM_IF_PIN && preset_valid_o)
        else $error("pin mode not selected");
    AST_PRESET: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        interface_select_i == SI_PIN |=> preset_config_o == $past(preset_select_pins_i))
        else $error("preset not taken from pins");
endmodule : slm_status_mon

// >>> rtl/slm_pkg.sv
// shared constants, register map and carrier types of the status pin lock monitor
package slm_pkg;
    // register indices; the bus places each at four times its index
    localparam int IDX_CTRL3 = 3;
    localparam int IDX_CTRL4 = 4;
    localparam int IDX_STAT21 = 21;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL3 = ADDR_W'(IDX_CTRL3 * 4);
    localparam logic [ADDR_W-1:0] ADDR_CTRL4 = ADDR_W'(IDX_CTRL4 * 4);
    localparam logic [ADDR_W-1:0] ADDR_STAT21 = ADDR_W'(IDX_STAT21 * 4);
    localparam int REG_W = 16;

    // control 3: per-pin vital enables
    localparam int EN0_SEL_BIT = 12;
    localparam int EN0_LOS_BIT = 11;
    localparam int EN0_LCK_BIT = 10;
    localparam int EN1_SEL_BIT = 9;
    localparam int EN1_LOS_BIT = 8;
    localparam int EN1_LCK_BIT = 7;
    localparam logic [REG_W-1:0] CTRL3_WMASK = 16'h1F80;
    localparam logic [REG_W-1:0] CTRL3_RST = 16'h0000;
    // control 4: secondary input enable
    localparam int SEC_EN_BIT = 5;
    localparam logic [REG_W-1:0] CTRL4_WMASK = 16'h0020;
    localparam logic [REG_W-1:0] CTRL4_RST = 16'h0000;
    // status 21: read-only vitals
    localparam int ST_SEL_BIT = 0;
    localparam int ST_LOS_BIT = 1;
    localparam int ST_UNLOCK_BIT = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [1:0] SI_SPI = 2'h0;
    localparam logic [1:0] SI_I2C = 2'h1;
    localparam logic [1:0] SI_PIN = 2'h2;
    localparam int PRESET_W = 5;

    // lock detector defaults: hold in update cycles, slip threshold in slips
    localparam int LD_HOLD_CYCLES = 1000;
    localparam int LD_SLIP_THRESHOLD = 0;

    typedef struct packed {
        logic sel_ref;
        logic ref_loss;
        logic unlock;
    } slm_vitals_t;

    typedef struct packed {
        logic sel;
        logic los;
        logic lck;
    } slm_pin_en_t;

    typedef enum logic [2:0] {
        SLM_IF_SPI = 3'h1,
        SLM_IF_I2C = 3'h2,
        SLM_IF_PIN = 3'h4
    } slm_if_t;

    typedef enum logic [1:0] {
        SLM_WR_IDLE = 2'h1,
        SLM_WR_RESP = 2'h2
    } slm_wr_state_t;
endpackage : slm_pkg

// >>> rtl/slm_lock_det.sv
// digital cycle-slip lock detector running on update-cycle enables
`timescale 1ns/1ps
module slm_lock_det #(
    parameter int HOLD_CYCLES = slm_pkg::LD_HOLD_CYCLES,
    parameter int SLIP_THRESHOLD = slm_pkg::LD_SLIP_THRESHOLD
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // phase detector edges
    input wire logic upd_i,
    input wire logic fb_i,
    // lock result
    output logic unlock_o,
    output logic slip_o
);
    import slm_pkg::*;
    localparam int HW = $clog2(HOLD_CYCLES + 1);
    localparam int CW = $clog2(SLIP_THRESHOLD + 2);
    localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYCLES);
    localparam logic [CW-1:0] THR = CW'(SLIP_THRESHOLD);

    logic signed [2:0] phase_reg;
    logic [CW-1:0] slip_cnt_reg;
    logic [HW-1:0] hold_reg;
    logic slip;

    // two edges of one kind with none of the other between them is one slipped cycle
    always_comb begin
        slip = 1'b0;
        if (upd_i && !fb_i && phase_reg == 3'sd1) begin
            slip = 1'b1;
        end else if (fb_i && !upd_i && phase_reg == -3'sd1) begin
            slip = 1'b1;
        end
    end
    assign slip_o = slip;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || slip) begin
            phase_reg <= 3'sd0;
        end else if (upd_i && !fb_i) begin
            // only the last edge kind is kept; a running sum would hide a lone
            // slip whenever the loop settled with feedback leading
            phase_reg <= 3'sd1;
        end else if (fb_i && !upd_i) begin
            phase_reg <= -3'sd1;
        end
    end

    // slips are counted; passing the threshold flags unlock and clears the count
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            slip_cnt_reg <= '0;
            hold_reg <= HOLD_LOAD;
            unlock_o <= 1'b1;
        end else if (slip && slip_cnt_reg >= THR) begin
            slip_cnt_reg <= '0;
            hold_reg <= HOLD_LOAD;
            unlock_o <= 1'b1;
        end else begin
            if (slip) begin
                slip_cnt_reg <= slip_cnt_reg + CW'(1);
            end
            // unlock lasts a full hold of clean update cycles, so a lone slip
            // shows as one high pulse and frequent slips keep it high
            if (upd_i && hold_reg != '0) begin
                hold_reg <= hold_reg - HW'(1);
            end
            if (upd_i && hold_reg == HW'(1)) begin
                unlock_o <= 1'b0;
            end
        end
    end

    AST_SLIP_FLAGS_UNLOCK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        slip && slip_cnt_reg >= THR |=> unlock_o && slip_cnt_reg == '0 && hold_reg == HOLD_LOAD)
        else $error("slip over threshold did not flag unlock");
    AST_HOLD_KEEPS_UNLOCK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        hold_reg != '0 |-> unlock_o)
        else $error("lock declared before hold expired");
    AST_RELOCK_AT_END: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        upd_i && hold_reg == HW'(1) && !slip |=> !unlock_o && hold_reg == '0)
        else $error("lock not declared at end of hold");
    AST_NO_SLIP_STAYS_LOCKED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !unlock_o && !slip |=> !unlock_o)
        else $error("unlock without slip");
endmodule : slm_lock_det

// >>> verification/slm_clk_partner.sv
// far-side model: reference update and feedback edge pulses of the loop
`timescale 1ns/1ps
module slm_clk_partner (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // slip request
    input wire logic skip_fb_i,
    // edge pulses
    output logic upd_o,
    output logic fb_o
);
    logic [1:0] ph_reg;
    // four-cycle update period; feedback lands mid-period while in step
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ph_reg <= 2'h0;
            upd_o <= 1'b0;
            fb_o <= 1'b0;
        end else begin
            ph_reg <= ph_reg + 2'h1;
            upd_o <= (ph_reg == 2'h3);
            // a swallowed feedback edge is one slipped cycle
            fb_o <= (ph_reg == 2'h1) && !skip_fb_i;
        end
    end
endmodule : slm_clk_partner

// >>> verification/slm_status_mon_tb_top.sv
// self-checking bench: register access, status pin routing, lock detection, mode select
`timescale 1ns/1ps
module slm_status_mon_tb_top;
    import slm_pkg::*;
    // short hold keeps relock waits small
    localparam int HOLD = 8;
    logic clk_sys_i, reset_i, skip_fb;
    logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, interface_select_i, rsp;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
    logic phase_detector_update_i, feedback_update_i, secondary_clock_input_sel_i;
    logic reference_present_i, preset_valid_o, monitor_out_zero_o, monitor_out_one_o;
    logic [PRESET_W-1:0] preset_select_pins_i, preset_config_o;
    slm_if_t interface_mode_o;
    logic [15:0] c3, c4;
    int n_mismatch = 0;
    int num_checks = 0;

    slm_status_mon #(.HOLD_CYCLES(HOLD), .SLIP_THRESHOLD(0)) slm_status_mon_inst (
        .clk_sys_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
        .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .phase_detector_update_i, .feedback_update_i, .secondary_clock_input_sel_i,
        .reference_present_i, .interface_select_i, .preset_select_pins_i, .interface_mode_o,
        .preset_config_o, .preset_valid_o, .monitor_out_zero_o, .monitor_out_one_o);
    slm_clk_partner slm_clk_partner_inst (.clk_sys_i, .reset_i, .skip_fb_i(skip_fb),
        .upd_o(phase_detector_update_i), .fb_o(feedback_update_i));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {16'h0000, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        rsp = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        // one idle edge so the next request never reassigns bready in this step
        @(posedge clk_sys_i);
    endtask : axi_wr

    task automatic axi_rd(input logic [ADDR_W-1:0] a);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o);
        rd = s_axi_rdata_o;
        rsp = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : axi_rd

    function automatic logic loss_exp;
        return c4[SEC_EN_BIT] ? !reference_present_i : 1'b1;
    endfunction : loss_exp

    function automatic logic pin(input logic [2:0] en, input logic unl);
        return (en[2] & secondary_clock_input_sel_i) | (en[1] & loss_exp()) | (en[0] & !unl);
    endfunction : pin

    // lets at least two update pulses pass before sampling the pins
    task automatic pins(input logic unl);
        repeat (12) @(posedge clk_sys_i);
        check("status pin zero", 32'(monitor_out_zero_o), 32'(pin(c3[12:10], unl)));
        check("status pin one", 32'(monitor_out_one_o), 32'(pin(c3[9:7], unl)));
    endtask : pins

    task automatic stat(input logic unl);
        axi_rd(ADDR_STAT21);
        check("status word", rd, {29'h0, unl, loss_exp(), secondary_clock_input_sel_i});
    endtask : stat

    task automatic wr_ctrl(input logic [15:0] v3, input logic [15:0] v4);
        c3 = v3;
        c4 = v4;
        axi_wr(ADDR_CTRL3, v3);
        axi_wr(ADDR_CTRL4, v4);
    endtask : wr_ctrl

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {reset_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'hF;
        {s_axi_arvalid_i, s_axi_rready_i, skip_fb, secondary_clock_input_sel_i} = 4'h0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
        s_axi_wstrb_i = 4'hF;
        reference_present_i = 1'b1;
        interface_select_i = 2'h0;
        preset_select_pins_i = 5'h00;
        c3 = CTRL3_RST;
        c4 = CTRL4_RST;
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (50) @(posedge clk_sys_i);
        axi_rd(ADDR_CTRL3);
        check("control 3 reset", rd, 32'h0000_0000);
        wr_ctrl(16'hFFFF, 16'hFFFF);
        check("write response", 32'(rsp), 32'(RESP_OKAY));
        axi_rd(ADDR_CTRL3);
        check("control 3 mask", rd, 32'h0000_1F80);
        axi_rd(ADDR_CTRL4);
        check("control 4 mask", rd, 32'h0000_0020);
        axi_wr(ADDR_STAT21, 16'h0007);
        c4 = 16'h0000;
        axi_wr(ADDR_CTRL4, c4);
        stat(1'b0);
        axi_rd(8'h40);
        check("unmapped response", 32'(rsp), 32'(RESP_SLVERR));
        check("unmapped read data", rd, 32'h0000_0000);
        axi_wr(8'h40, 16'h0001);
        check("unmapped write response", 32'(rsp), 32'(RESP_SLVERR));
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            wr_ctrl(16'h0080 << i, 16'h0020);
            for (int v = 0; v < 4; v++) begin
                secondary_clock_input_sel_i <= v[0];
                reference_present_i <= v[1];
                pins(1'b0);
            end
        end
        $display("test routing done");
        secondary_clock_input_sel_i <= 1'b0;
        reference_present_i <= 1'b1;
        wr_ctrl(16'h0C80, 16'h0020);
        pins(1'b0);
        skip_fb <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        skip_fb <= 1'b0;
        reference_present_i <= 1'b0;
        pins(1'b1);
        stat(1'b1);
        reference_present_i <= 1'b1;
        repeat (60) @(posedge clk_sys_i);
        pins(1'b0);
        stat(1'b0);
        skip_fb <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        pins(1'b1);
        skip_fb <= 1'b0;
        repeat (80) @(posedge clk_sys_i);
        c4 = 16'h0000;
        axi_wr(ADDR_CTRL4, c4);
        pins(1'b0);
        $display("test lock detect done");
        for (int k = 0; k < 4; k++) begin
            interface_select_i <= k[1:0];
            preset_select_pins_i <= 5'(k) + 5'h09;
            repeat (3) @(posedge clk_sys_i);
            check("interface mode", 32'(interface_mode_o),
                32'(k == 1 ? SLM_IF_I2C : (k == 2 ? SLM_IF_PIN : SLM_IF_SPI)));
            check("preset valid", 32'(preset_valid_o), 32'(k == 2));
            if (k >= 2) check("preset config", 32'(preset_config_o), 32'h0000_000B);
        end
        $display("test interface select done");
        print_verdict();
    end
endmodule : slm_status_mon_tb_top
